// [rail_margin_pkg.sv]
`default_nettype none
package rail_margin_pkg;

    // ========================================
    // Widths
    localparam int DUTY_W = 16;
    localparam int VOLT_W = 12;
    localparam int STEP_W = 15;

    // ========================================
    // Margin mode when not margining
    localparam logic [1:0] MODE_TRISTATE = 2'h0;
    localparam logic [1:0] MODE_TRIM = 2'h1;
    localparam logic [1:0] MODE_FIXED = 2'h2;

    // ========================================
    // Bus margin command field
    localparam logic [1:0] MARGIN_NONE = 2'h0;
    localparam logic [1:0] MARGIN_LOW = 2'h1;
    localparam logic [1:0] MARGIN_HIGH = 2'h2;

    // ========================================
    // Timing
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int STEP_TIME_US = 500;
    localparam int STEP_CYCLES_DEFAULT = (CLK_FREQ_HZ / 1_000_000) * STEP_TIME_US;

    // Pulse frequency limits, period in clock cycles
    localparam int FREQ_MIN_HZ = 15_275;
    localparam int FREQ_MAX_HZ = 125_000_000;
    localparam logic [DUTY_W-1:0] PERIOD_MIN = 16'h0002;
    localparam logic [DUTY_W-1:0] PERIOD_MAX = 16'(CLK_FREQ_HZ / FREQ_MIN_HZ);

    // ========================================
    // Reset values
    localparam logic [DUTY_W-1:0] DUTY_RESET = 16'h0000;
    localparam logic [DUTY_W-1:0] PERIOD_RESET = 16'h0032;
    localparam logic [STEP_W-1:0] STEP_CNT_RESET = 15'h0000;

    typedef enum logic [2:0] {
        st_off,
        st_tristate,
        st_fixed,
        st_trim,
        st_margin
    } ctrl_state_type;

endpackage : rail_margin_pkg
`default_nettype wire

// [pwm_if.sv]
`default_nettype none
interface pwm_if;
    import rail_margin_pkg::*;
    logic [DUTY_W-1:0] period;
    logic [DUTY_W-1:0] duty;
    logic pulse;
    modport ctrl (output period, output duty, input pulse);
    modport gen (input period, input duty, output pulse);
endinterface : pwm_if
`default_nettype wire

// [margin_pulse_gen.sv]
`default_nettype none
module margin_pulse_gen
    import rail_margin_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Period, duty and pulse
    pwm_if.gen bus
);

    logic [DUTY_W-1:0] cnt;
    logic [DUTY_W-1:0] next_cnt;
    logic pulse;
    logic next_pulse;

    always_comb begin
        if (cnt >= bus.period - 16'h0001) begin
            next_cnt = DUTY_RESET;
        end else begin
            next_cnt = cnt + 16'h0001;
        end
        next_pulse = (cnt < bus.duty);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cnt <= DUTY_RESET;
            pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pulse <= next_pulse;
        end
    end

    assign bus.pulse = pulse;

    wrap_period_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (cnt >= bus.period - 16'h0001) |=> (cnt == 16'h0000))
        else $error("pulse counter did not wrap at period");

endmodule : margin_pulse_gen
`default_nettype wire

// [rail_margin_pwm_control.sv]
// Functional notes
// - Tri-state mode: output undriven when not margining
// - Trim mode: track nominal setpoint when not margining
// - Fixed mode: constant configured duty, no correction
// - Config bit: ignore faults on pin margining
// - Polarity bit sets duty versus voltage direction
// - Margining requested by bus command or pin
// - Pins: one enables margining, one picks direction
// - Bus command carries its own fault action
// - No margining before power-good seen once
// - Correction steps one unit every 500 us
// - Start driving at configured initial duty
// - Pulse frequency configurable, 15.275 kHz upward
`default_nettype none
module rail_margin_pwm_control
    import rail_margin_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Configuration
    input wire logic [1:0] margin_mode_i,
    input wire logic pin_ignore_fault_i,
    input wire logic duty_raises_volt_i,
    input wire logic [DUTY_W-1:0] init_duty_i,
    input wire logic [DUTY_W-1:0] period_i,
    input wire logic [VOLT_W-1:0] vout_setpoint_i,
    input wire logic [VOLT_W-1:0] margin_high_i,
    input wire logic [VOLT_W-1:0] margin_low_i,
    // Management bus margin command
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_margin_i,
    input wire logic cmd_ignore_fault_i,
    // General input pins
    input wire logic general_input_pin_en_i,
    input wire logic general_input_pin_high_i,
    // Rail monitoring
    input wire logic rail_enable_i,
    input wire logic power_good_i,
    input wire logic [VOLT_W-1:0] vout_meas_i,
    input wire logic ov_fault_i,
    input wire logic uv_fault_i,
    // Pulse output pin
    output logic margin_pulse_output_o,
    output logic margin_pulse_output_oe_o,
    // Status
    output logic margining_o,
    output logic margin_high_o,
    output logic pg_seen_o,
    output logic fault_act_o,
    output logic [DUTY_W-1:0] duty_o
);

    // ========================================
    // Margin request sources
    logic [1:0] cmd_margin;
    logic cmd_ignore;
    logic [1:0] next_cmd_margin;
    logic next_cmd_ignore;
    logic pg_seen;
    logic next_pg_seen;
    logic req;
    logic req_high;
    logic req_ignore;

    always_comb begin
        next_cmd_margin = cmd_margin;
        next_cmd_ignore = cmd_ignore;
        if (cmd_valid_i) begin
            next_cmd_margin = cmd_margin_i;
            next_cmd_ignore = cmd_ignore_fault_i;
        end
        if (!rail_enable_i) begin
            next_pg_seen = 1'b0;
        end else begin
            next_pg_seen = pg_seen | power_good_i;
        end
        // Pin request overrides the bus command
        if (general_input_pin_en_i) begin
            req = 1'b1;
            req_high = general_input_pin_high_i;
            req_ignore = pin_ignore_fault_i;
        end else begin
            req = (cmd_margin == MARGIN_LOW) || (cmd_margin == MARGIN_HIGH);
            req_high = (cmd_margin == MARGIN_HIGH);
            req_ignore = cmd_ignore;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cmd_margin <= MARGIN_NONE;
            cmd_ignore <= 1'b0;
            pg_seen <= 1'b0;
        end else begin
            cmd_margin <= next_cmd_margin;
            cmd_ignore <= next_cmd_ignore;
            pg_seen <= next_pg_seen;
        end
    end

    // ========================================
    // Correction step timer
    logic [STEP_W-1:0] step_cnt;
    logic [STEP_W-1:0] next_step_cnt;
    logic step_tick;
    logic next_step_tick;

    always_comb begin
        if (step_cnt == STEP_W'(STEP_CYCLES - 1)) begin
            next_step_cnt = STEP_CNT_RESET;
            next_step_tick = 1'b1;
        end else begin
            next_step_cnt = step_cnt + 15'h0001;
            next_step_tick = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            step_cnt <= STEP_CNT_RESET;
            step_tick <= 1'b0;
        end else begin
            step_cnt <= next_step_cnt;
            step_tick <= next_step_tick;
        end
    end

    // ========================================
    // Mode control and duty
    ctrl_state_type state;
    ctrl_state_type next_state;
    logic [DUTY_W-1:0] duty;
    logic [DUTY_W-1:0] next_duty;
    logic [DUTY_W-1:0] period;
    logic [DUTY_W-1:0] next_period;
    logic margining;
    logic next_margining;
    logic margin_high;
    logic next_margin_high;
    logic ignore_eff;
    logic next_ignore_eff;
    logic fault_act;
    logic next_fault_act;
    logic oe;
    logic next_oe;
    logic [VOLT_W-1:0] target;
    logic duty_up;
    logic duty_down;

    function automatic logic drives(input ctrl_state_type s);
        drives = (s == st_fixed) || (s == st_trim) || (s == st_margin);
    endfunction : drives

    always_comb begin
        next_margining = req && pg_seen && rail_enable_i;
        next_margin_high = next_margining && req_high;
        next_ignore_eff = next_margining && req_ignore;
        next_fault_act = (ov_fault_i || uv_fault_i) && !(margining && ignore_eff);
        if (period_i < PERIOD_MIN) begin
            next_period = PERIOD_MIN;
        end else if (period_i > PERIOD_MAX) begin
            next_period = PERIOD_MAX;
        end else begin
            next_period = period_i;
        end
        if (!rail_enable_i) begin
            next_state = st_off;
        end else if (next_margining) begin
            next_state = st_margin;
        end else begin
            case (margin_mode_i)
                MODE_TRIM: next_state = st_trim;
                MODE_FIXED: next_state = st_fixed;
                default: next_state = st_tristate;
            endcase
        end
        if (state != st_margin) begin
            target = vout_setpoint_i;
        end else if (margin_high) begin
            target = margin_high_i;
        end else begin
            target = margin_low_i;
        end
        // Raise voltage means up when duty raises voltage
        duty_up = (vout_meas_i < target) == duty_raises_volt_i;
        duty_down = (vout_meas_i > target) == duty_raises_volt_i;
        if (vout_meas_i == target) begin
            duty_up = 1'b0;
            duty_down = 1'b0;
        end
        next_duty = duty;
        if (!drives(state) || next_state == st_fixed) begin
            next_duty = init_duty_i;
        end else if (step_tick && (state == st_trim || state == st_margin)) begin
            if (duty_up && duty < period) begin
                next_duty = duty + 16'h0001;
            end else if (duty_down && duty != 16'h0000) begin
                next_duty = duty - 16'h0001;
            end
        end
        next_oe = drives(next_state);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state <= st_off;
            duty <= DUTY_RESET;
            period <= PERIOD_RESET;
            margining <= 1'b0;
            margin_high <= 1'b0;
            ignore_eff <= 1'b0;
            fault_act <= 1'b0;
            oe <= 1'b0;
        end else begin
            state <= next_state;
            duty <= next_duty;
            period <= next_period;
            margining <= next_margining;
            margin_high <= next_margin_high;
            ignore_eff <= next_ignore_eff;
            fault_act <= next_fault_act;
            oe <= next_oe;
        end
    end

    // ========================================
    // Pulse generator
    pwm_if pwm_bus ();

    assign pwm_bus.period = period;
    assign pwm_bus.duty = duty;

    margin_pulse_gen pulse_gen (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .bus(pwm_bus.gen)
    );

    assign margin_pulse_output_o = pwm_bus.pulse;
    assign margin_pulse_output_oe_o = oe;
    assign margining_o = margining;
    assign margin_high_o = margin_high;
    assign pg_seen_o = pg_seen;
    assign fault_act_o = fault_act;
    assign duty_o = duty;

    // ========================================
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence fixed_two_s;
        (state == st_fixed) ##1 (state == st_fixed);
    endsequence

    sequence bus_high_s;
        (cmd_valid_i && cmd_margin_i == MARGIN_HIGH && !general_input_pin_en_i
            && pg_seen && rail_enable_i) ##1 (!general_input_pin_en_i && rail_enable_i);
    endsequence

    tri_hiz_a: assert property ((state == st_tristate) |-> !oe)
        else $error("tri-state mode drives the pin");

    trim_up_a: assert property ((state == st_trim && step_tick && duty_up
        && duty < period && next_state == st_trim) |=> (duty == $past(duty) + 16'h0001))
        else $error("trim step did not raise duty");

    fixed_duty_a: assert property (fixed_two_s |-> (duty == $past(init_duty_i)))
        else $error("fixed mode duty differs from configuration");

    fault_ignore_a: assert property ((margining && ignore_eff
        && (ov_fault_i || uv_fault_i)) |=> !fault_act)
        else $error("fault passed while ignored");

    fault_pass_a: assert property ((!margining && (ov_fault_i || uv_fault_i))
        |=> fault_act)
        else $error("fault dropped while not margining");

    margin_dir_a: assert property ((state == st_margin && step_tick && margin_high
        && !duty_raises_volt_i && vout_meas_i < margin_high_i && duty != 16'h0000
        && next_state == st_margin) |=> (duty == $past(duty) - 16'h0001))
        else $error("inverted polarity step wrong");

    bus_cmd_a: assert property (bus_high_s |=> (margining && margin_high))
        else $error("bus margin high not applied");

    pin_dir_a: assert property ((general_input_pin_en_i && general_input_pin_high_i
        && pg_seen && rail_enable_i) |=> (margining && margin_high))
        else $error("pin margin high not applied");

    pg_gate_a: assert property ((!pg_seen) |=> !margining)
        else $error("margining before power good");

    step_gap_a: assert property (step_tick |=> !step_tick [*8])
        else $error("correction steps too close");

    hold_between_a: assert property ((state == st_trim && !step_tick
        && next_state == st_trim) |=> $stable(duty))
        else $error("duty moved between steps");

    init_duty_a: assert property ($rose(oe) |-> (duty == $past(init_duty_i)))
        else $error("drive started without initial duty");

endmodule : rail_margin_pwm_control
`default_nettype wire

// [rc_trim_model.sv]
`default_nettype none
module rc_trim_model #(
    parameter real TAU = 256.0
) (
    // Clock
    input wire logic clk_sys_i,
    // Pulse pin and converter reference
    input wire logic pulse_i,
    input wire logic oe_i,
    input wire logic [11:0] ref_i,
    // Filtered rail voltage
    output logic [11:0] vout_o
);
    timeunit 1ns;
    timeprecision 1ns;
    real v = 2048.0;
    // ========================================
    // RC filter, undriven pin settles to reference
    always @(posedge clk_sys_i) begin
        v = v + ((oe_i ? (pulse_i ? 4095.0 : 0.0) : real'(ref_i)) - v) / TAU;
        vout_o <= 12'(int'(v));
    end
endmodule : rc_trim_model
`default_nettype wire

// [tb_top.sv]
`default_nettype none
`define CMP(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top
    import rail_margin_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 16;
    typedef struct {logic [1:0] sel; logic [15:0] exp;} note_type;
    note_type notes[$];
    note_type n;
    int errors = 0, samples_checked = 0, k, seed = 32'hD0A2;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0;
    logic [1:0] mode = MODE_TRISTATE, cmd_m = MARGIN_NONE;
    logic pin_ign = 1'b0, raises = 1'b1, cmd_v = 1'b0, cmd_ign = 1'b0;
    logic pin_en = 1'b0, pin_hi = 1'b0, rail_en = 1'b0, pg = 1'b0, ov = 1'b0, uv = 1'b0;
    logic use_model = 1'b0;
    logic [15:0] init = 16'h000A, period = 16'h0020, cnt = 16'h0000;
    logic [11:0] setpt = 12'h800, mhi = 12'h800, mlo = 12'h800, vtb = 12'h800;
    logic [11:0] vmod, vmeas;
    logic pout, oe, marg, mhigh, pgs, fact;
    logic [15:0] duty;
    wire logic [4:0] flags = {oe, marg, mhigh, pgs, fact};
    assign vmeas = use_model ? vmod : vtb;
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    rail_margin_pwm_control #(.STEP_CYCLES(STEP)) dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .margin_mode_i(mode),
        .pin_ignore_fault_i(pin_ign), .duty_raises_volt_i(raises), .init_duty_i(init),
        .period_i(period), .vout_setpoint_i(setpt), .margin_high_i(mhi), .margin_low_i(mlo),
        .cmd_valid_i(cmd_v), .cmd_margin_i(cmd_m), .cmd_ignore_fault_i(cmd_ign),
        .general_input_pin_en_i(pin_en), .general_input_pin_high_i(pin_hi),
        .rail_enable_i(rail_en), .power_good_i(pg), .vout_meas_i(vmeas), .ov_fault_i(ov),
        .uv_fault_i(uv), .margin_pulse_output_o(pout), .margin_pulse_output_oe_o(oe),
        .margining_o(marg), .margin_high_o(mhigh), .pg_seen_o(pgs), .fault_act_o(fact),
        .duty_o(duty));
    rc_trim_model #(.TAU(256.0)) rc (
        .clk_sys_i(clk_sys_i), .pulse_i(pout), .oe_i(oe), .ref_i(setpt), .vout_o(vmod));
    // ========================================
    // Tasks
    task automatic cyc(input int c);
        repeat (c) @(negedge clk_sys_i);
    endtask : cyc
    task automatic note(input logic [1:0] sel, input logic [15:0] exp);
        notes.push_back('{sel, exp});
    endtask : note
    task automatic cmd(input logic [1:0] m, input logic ign);
        cmd_v = 1'b1;
        cmd_m = m;
        cmd_ign = ign;
        cyc(1);
        cmd_v = 1'b0;
        cyc(3);
    endtask : cmd
    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // ========================================
    // Monitor takes all pending notes, oldest first
    initial begin
        forever begin
            @(negedge clk_sys_i);
            #1;
            while (notes.size() > 0) begin
                n = notes.pop_front();
                `CMP((n.sel == 2'h0 ? {11'h000, flags} : (n.sel == 2'h1 ? duty : cnt)), n.exp)
            end
        end
    end
    initial begin
        repeat (10000) @(posedge clk_sys_i);
        errors++;
        give_verdict();
    end
    // ========================================
    // Stimulus
    initial begin
        cyc(20);
        note(0, 16'h0000);
        rst_b_i = 1'b1;
        rail_en = 1'b1;
        pin_en = 1'b1;
        pin_hi = 1'b1;
        cyc(4);
        note(0, 16'h0000);
        pg = 1'b1;
        cyc(1);
        pg = 1'b0;
        cyc(3);
        note(0, 16'h001E);
        note(1, 16'h000A);
        pin_hi = 1'b0;
        cyc(3);
        note(0, 16'h001A);
        uv = 1'b1;
        for (k = 0; k < 2; k++) begin
            pin_ign = ~k[0];
            cyc(3);
            note(0, {11'h000, 5'h1A | 5'(k)});
        end
        uv = 1'b0;
        pin_en = 1'b0;
        cyc(3);
        note(0, 16'h0002);
        ov = 1'b1;
        cmd(MARGIN_HIGH, 1'b1);
        note(0, 16'h001E);
        cmd(MARGIN_LOW, 1'b0);
        note(0, 16'h001B);
        cmd(MARGIN_NONE, 1'b0);
        note(0, 16'h0003);
        ov = 1'b0;
        mode = MODE_FIXED;
        repeat (4) begin
            init = 16'($random(seed)) & 16'h001F;
            cyc(3);
            note(1, init);
            note(0, 16'h0012);
        end
        init = 16'h000C;
        cyc(3);
        repeat (32) begin
            cyc(1);
            cnt = cnt + 16'(pout);
        end
        note(2, 16'h000C);
        init = 16'h0010;
        cyc(3);
        // Trim: meas below setpoint, duty climbs one unit a step
        setpt = 12'h900;
        mode = MODE_TRIM;
        k = 0;
        while (duty === 16'h0010 && k < 40) begin
            cyc(1);
            k++;
        end
        note(1, 16'h0011);
        cyc(8);
        note(1, 16'h0011);
        cyc(STEP);
        note(1, 16'h0012);
        raises = 1'b0;
        cyc(32);
        note(1, 16'h0010);
        pin_en = 1'b1;
        pin_hi = 1'b1;
        mhi = 12'h900;
        cyc(64);
        note(1, 16'h000C);
        pin_hi = 1'b0;
        mlo = 12'h700;
        cyc(64);
        note(1, 16'h0010);
        rail_en = 1'b0;
        cyc(3);
        note(0, 16'h0000);
        rail_en = 1'b1;
        cyc(3);
        note(0, 16'h0010);
        // Closed loop through the filter model
        pin_en = 1'b0;
        raises = 1'b1;
        setpt = 12'h800;
        init = 16'h000A;
        use_model = 1'b1;
        cyc(3000);
        cnt = 16'(vmod > 12'h600 && vmod < 12'hA00);
        note(2, 16'h0001);
        cyc(2);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
